// file: dlic_top.sv
// Dual level interrupt controller: sources, masking, steering, registers
//
// Function
// - Four active-high sideband request inputs accepted
// - Fast request at bit 0, also general
// - Breakpoint bit 15, jtag bit 14
// - User requests 2,1,0 at bits 13-11
// - DMA channels 3..0 at bits 10..7
// - Watchdog request at bit 6
// - Serial 1 bit 5, serial 0 bit 2
// - Timer 1 bit 4, timer 0 bit 3
// - Software request bit 1, set/cleared by write
// - Register map at documented offsets
// - General masked bits 15:1 active and enabled
// - General raw bits 15:1 unmasked source state
// - General masked bit 0 shows fast request
// - General raw bit 0 shows fast source
// - Status registers read zero after reset
// - Level sensitive sources, priority left to software
// - Enable set writes set only one bits
// - Enable clear writes clear only one bits
// - Steered sources report only in fast status
`timescale 1ns/1ps
module dlic_top (
  input  wire logic                        ref_clk,
  input  wire logic                        reset_n,
  input  wire logic                        fastRequestIn,
  input  wire logic [2:0]                  userRequestIn,
  input  wire dlic_pkg::dlic_periph_type   periphRequest,
  input  wire dlic_pkg::dlic_bus_req_type  busReq,
  output logic      [dlic_pkg::DATA_W-1:0] busRdata,
  output logic                             busRvalid,
  output logic                             generalRequest,
  output logic                             fastRequest
);

  dlic_pkg::dlic_state_type state_r;
  dlic_pkg::dlic_state_type state_nxt;

  logic [dlic_pkg::PIN_W-1:0] pinLevel;
  logic [dlic_pkg::SRC_W-1:0] sourceNow;
  logic [dlic_pkg::SRC_W-1:0] genRaw;
  logic [dlic_pkg::SRC_W-1:0] genMasked;
  logic [dlic_pkg::SRC_W-1:0] fastRaw;
  logic [dlic_pkg::SRC_W-1:0] fastMasked;

  // Address match for a selected access at the given offset, read or write alike
  function automatic logic hit(
    input dlic_pkg::dlic_bus_req_type req,
    input logic [dlic_pkg::ADDR_W-1:0] ofs
  );
    hit = req.sel && (req.addr == ofs);
  endfunction : hit

  // Zero-extend a 16-bit status word onto the data bus
  function automatic logic [dlic_pkg::DATA_W-1:0] widen(
    input logic [dlic_pkg::SRC_W-1:0] val
  );
    widen = {{(dlic_pkg::DATA_W - dlic_pkg::SRC_W){1'b0}}, val};
  endfunction : widen

  // Pins cross into the clock domain before use
  dlic_sync u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .pinIn    ({fastRequestIn, userRequestIn}),
    .pinLevel (pinLevel)
  );

  // Source vector; every input is a level, no latching here
  always_comb begin
    sourceNow = dlic_pkg::SRC_RESET;
    sourceNow[dlic_pkg::BIT_FAST]       =
      pinLevel[dlic_pkg::PIN_FAST];
    sourceNow[dlic_pkg::BIT_SOFTWARE]   = state_r.softRequest;
    sourceNow[dlic_pkg::BIT_UART0]      = periphRequest.uart0;
    sourceNow[dlic_pkg::BIT_TIMER0]     = periphRequest.timer0;
    sourceNow[dlic_pkg::BIT_TIMER1]     = periphRequest.timer1;
    sourceNow[dlic_pkg::BIT_UART1]      = periphRequest.uart1;
    sourceNow[dlic_pkg::BIT_WATCHDOG]   = periphRequest.watchdog;
    sourceNow[dlic_pkg::BIT_DMA0 +: 4]  = periphRequest.dma;
    sourceNow[dlic_pkg::BIT_USER0 +: 3] = pinLevel[2:0];
    sourceNow[dlic_pkg::BIT_JTAG]       = periphRequest.jtag;
    sourceNow[dlic_pkg::BIT_BREAKPOINT] = periphRequest.breakpoint;
  end

  // Status views from the sampled sources
  always_comb begin
    genRaw     = (state_r.source & ~state_r.steering
                  & dlic_pkg::GENERAL_MASK)
               | (state_r.source & dlic_pkg::FAST_MASK);
    fastRaw    = (state_r.source & state_r.steering
                  & dlic_pkg::GENERAL_MASK)
               | (state_r.source & dlic_pkg::FAST_MASK);
    fastMasked = (fastRaw & state_r.genEnable
                  & dlic_pkg::GENERAL_MASK)
               | (fastRaw & {{(dlic_pkg::SRC_W-1){1'b0}},
                             state_r.fastEnable});
    genMasked  = (genRaw & state_r.genEnable
                  & dlic_pkg::GENERAL_MASK)
               | (fastMasked & dlic_pkg::FAST_MASK);
  end

  always_comb begin
    state_nxt           = state_r;
    state_nxt.source    = sourceNow;
    state_nxt.readValid = 1'b0;
    state_nxt.readData  = dlic_pkg::DATA_ZERO;

    // Request lines follow status; a cycle of lag keeps outputs registered
    state_nxt.generalRequest = |genMasked;
    state_nxt.fastRequest    = |fastMasked;

    if (busReq.sel && busReq.write) begin
      if (hit(busReq, dlic_pkg::OFS_GEN_EN_SET)) begin
        state_nxt.genEnable = state_r.genEnable
                            | (busReq.wdata[dlic_pkg::SRC_W-1:0]
                               & dlic_pkg::GENERAL_MASK);
      end
      if (hit(busReq, dlic_pkg::OFS_GEN_EN_CLR)) begin
        state_nxt.genEnable = state_r.genEnable
                            & ~(busReq.wdata[dlic_pkg::SRC_W-1:0]
                                & dlic_pkg::GENERAL_MASK);
      end
      if (hit(busReq, dlic_pkg::OFS_SOFT_REQ)) begin
        state_nxt.softRequest =
          busReq.wdata[dlic_pkg::BIT_SOFTWARE];
      end
      if (hit(busReq, dlic_pkg::OFS_FAST_EN_SET)
          && busReq.wdata[dlic_pkg::BIT_FAST]) begin
        state_nxt.fastEnable = 1'b1;
      end
      if (hit(busReq, dlic_pkg::OFS_FAST_EN_CLR)
          && busReq.wdata[dlic_pkg::BIT_FAST]) begin
        state_nxt.fastEnable = 1'b0;
      end
      if (hit(busReq, dlic_pkg::OFS_STEERING)) begin
        // Only general sources can be steered
        state_nxt.steering = busReq.wdata[dlic_pkg::SRC_W-1:0]
                           & dlic_pkg::GENERAL_MASK;
      end
    end

    if (busReq.sel && !busReq.write) begin
      state_nxt.readValid = 1'b1;
      // Write-only and unmapped offsets read as zero
      unique case (busReq.addr)
        dlic_pkg::OFS_GEN_MASKED:  state_nxt.readData = widen(genMasked);
        dlic_pkg::OFS_GEN_RAW:     state_nxt.readData = widen(genRaw);
        dlic_pkg::OFS_GEN_EN_SET:  state_nxt.readData =
                                     widen(state_r.genEnable);
        dlic_pkg::OFS_FAST_MASKED: state_nxt.readData = widen(fastMasked);
        dlic_pkg::OFS_FAST_RAW:    state_nxt.readData = widen(fastRaw);
        dlic_pkg::OFS_FAST_EN_SET: state_nxt.readData =
          widen({{(dlic_pkg::SRC_W-1){1'b0}}, state_r.fastEnable});
        default:                   state_nxt.readData = dlic_pkg::DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '{genEnable:      dlic_pkg::SRC_RESET,
                   fastEnable:     1'b0,
                   steering:       dlic_pkg::SRC_RESET,
                   softRequest:    1'b0,
                   source:         dlic_pkg::SRC_RESET,
                   readData:       dlic_pkg::DATA_ZERO,
                   readValid:      1'b0,
                   generalRequest: 1'b0,
                   fastRequest:    1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign busRdata       = state_r.readData;
  assign busRvalid      = state_r.readValid;
  assign generalRequest = state_r.generalRequest;
  assign fastRequest    = state_r.fastRequest;

endmodule : dlic_top

// file: dlic_pkg.sv
// Shared constants and carrier types of the dual level interrupt controller
package dlic_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SRC_W  = 16;
  localparam int unsigned PIN_W  = 4;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_GEN_MASKED  = 9'h000;
  localparam logic [ADDR_W-1:0] OFS_GEN_RAW     = 9'h004;
  localparam logic [ADDR_W-1:0] OFS_GEN_EN_SET  = 9'h008;
  localparam logic [ADDR_W-1:0] OFS_GEN_EN_CLR  = 9'h00C;
  localparam logic [ADDR_W-1:0] OFS_SOFT_REQ    = 9'h010;
  localparam logic [ADDR_W-1:0] OFS_FAST_MASKED = 9'h100;
  localparam logic [ADDR_W-1:0] OFS_FAST_RAW    = 9'h104;
  localparam logic [ADDR_W-1:0] OFS_FAST_EN_SET = 9'h108;
  localparam logic [ADDR_W-1:0] OFS_FAST_EN_CLR = 9'h10C;
  localparam logic [ADDR_W-1:0] OFS_STEERING    = 9'h110;

  // Source bit positions
  localparam int unsigned BIT_FAST       = 0;
  localparam int unsigned BIT_SOFTWARE   = 1;
  localparam int unsigned BIT_UART0      = 2;
  localparam int unsigned BIT_TIMER0     = 3;
  localparam int unsigned BIT_TIMER1     = 4;
  localparam int unsigned BIT_UART1      = 5;
  localparam int unsigned BIT_WATCHDOG   = 6;
  localparam int unsigned BIT_DMA0       = 7;
  localparam int unsigned BIT_USER0      = 11;
  localparam int unsigned BIT_JTAG       = 14;
  localparam int unsigned BIT_BREAKPOINT = 15;

  // Bits 15:1 are the general sources; bit 0 is the fast source
  localparam logic [SRC_W-1:0]  GENERAL_MASK = 16'hFFFE;
  localparam logic [SRC_W-1:0]  FAST_MASK    = 16'h0001;
  localparam logic [SRC_W-1:0]  SRC_RESET    = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO    = 32'h0000_0000;

  // Pin order inside the synchroniser vector
  localparam int unsigned PIN_FAST  = 3;
  localparam logic [PIN_W-1:0] PIN_RESET = 4'h0;

  typedef struct packed {
    logic                 sel;
    logic                 write;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wdata;
  } dlic_bus_req_type;

  typedef struct packed {
    logic                 breakpoint;
    logic                 jtag;
    logic [3:0]           dma;
    logic                 watchdog;
    logic                 uart1;
    logic                 timer1;
    logic                 timer0;
    logic                 uart0;
  } dlic_periph_type;

  typedef struct packed {
    logic [PIN_W-1:0]     stage1;
    logic [PIN_W-1:0]     stage2;
    logic [PIN_W-1:0]     stage3;
    logic [PIN_W-1:0]     level;
  } dlic_sync_state_type;

  typedef struct packed {
    logic [SRC_W-1:0]     genEnable;
    logic                 fastEnable;
    logic [SRC_W-1:0]     steering;
    logic                 softRequest;
    logic [SRC_W-1:0]     source;
    logic [DATA_W-1:0]    readData;
    logic                 readValid;
    logic                 generalRequest;
    logic                 fastRequest;
  } dlic_state_type;

endpackage : dlic_pkg

// file: dlic_sync.sv
// Three stage synchroniser with agreement filter for the request pins
`timescale 1ns/1ps
module dlic_sync (
  input  wire logic                        ref_clk,
  input  wire logic                        reset_n,
  input  wire logic [dlic_pkg::PIN_W-1:0]  pinIn,
  output logic      [dlic_pkg::PIN_W-1:0]  pinLevel
);

  dlic_pkg::dlic_sync_state_type state_r;
  dlic_pkg::dlic_sync_state_type state_nxt;

  always_comb begin
    state_nxt        = state_r;
    state_nxt.stage1 = pinIn;
    state_nxt.stage2 = state_r.stage1;
    state_nxt.stage3 = state_r.stage2;
    // A change counts only once two later stages agree
    for (int i = 0; i < dlic_pkg::PIN_W; i++) begin
      if (state_r.stage2[i] == state_r.stage3[i]) begin
        state_nxt.level[i] = state_r.stage3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '{stage1: dlic_pkg::PIN_RESET, stage2: dlic_pkg::PIN_RESET,
                   stage3: dlic_pkg::PIN_RESET, level: dlic_pkg::PIN_RESET};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pinLevel = state_r.level;

endmodule : dlic_sync

// file: dlic_pin_model.sv
// Fabric side model driving the sideband request pins
`timescale 1ns/1ps
module dlic_pin_model (
  input  wire logic [3:0] levelReq,
  output logic            fastRequestIn,
  output logic [2:0]      userRequestIn
);
  // Plain levels; the bench keeps every unused request low
  assign fastRequestIn = levelReq[3];
  assign userRequestIn = levelReq[2:0];
endmodule : dlic_pin_model

// file: dlic_checker_assertions.sv
// Bus and request line checker of the interrupt controller
`timescale 1ns/1ps
module dlic_checker (
  input wire logic                        ref_clk,
  input wire logic                        reset_n,
  input wire logic                        fastRequestIn,
  input wire logic [2:0]                  userRequestIn,
  input wire dlic_pkg::dlic_periph_type   periphRequest,
  input wire dlic_pkg::dlic_bus_req_type  busReq,
  input wire logic [dlic_pkg::DATA_W-1:0] busRdata,
  input wire logic                        busRvalid,
  input wire logic                        generalRequest,
  input wire logic                        fastRequest
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic rdReq;
  logic wrReq;
  assign rdReq = busReq.sel && !busReq.write;
  assign wrReq = busReq.sel && busReq.write;
  property p_rd_ans; rdReq |=> busRvalid; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_rd_only; busRvalid |-> $past(rdReq); endproperty
  a_rd_only: assert property (p_rd_only)
    else $error("answer without read");
  property p_rsv_zero; busRvalid |-> busRdata[31:16] == 16'h0000; endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved bits set");
  property p_idle_zero; !busRvalid |-> busRdata == 32'h0000_0000; endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("data outside answer");
  property p_wr_silent; wrReq |=> !busRvalid; endproperty
  a_wr_silent: assert property (p_wr_silent)
    else $error("write answered");
  property p_wo_zero;
    rdReq && busReq.addr inside {9'h00C, 9'h010, 9'h110}
      |=> busRdata == 32'h0000_0000;
  endproperty
  a_wo_zero: assert property (p_wo_zero)
    else $error("write-only place read nonzero");
  property p_set_read;
    wrReq && busReq.addr == 9'h008 ##1 rdReq && busReq.addr == 9'h008
      |=> (busRdata[15:1] & $past(busReq.wdata[15:1], 2))
          == $past(busReq.wdata[15:1], 2);
  endproperty
  a_set_read: assert property (p_set_read)
    else $error("enable bit not set");
  property p_clr_read;
    wrReq && busReq.addr == 9'h00C ##1 rdReq && busReq.addr == 9'h008
      |=> (busRdata[15:1] & $past(busReq.wdata[15:1], 2)) == 15'h0000;
  endproperty
  a_clr_read: assert property (p_clr_read)
    else $error("enable bit not cleared");
  property p_reset_quiet;
    $rose(reset_n) |-> !generalRequest && !fastRequest;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("request out of reset");
endmodule : dlic_checker

bind dlic_top dlic_checker chk_u (.ref_clk(ref_clk), .reset_n(reset_n),
  .fastRequestIn(fastRequestIn), .userRequestIn(userRequestIn),
  .periphRequest(periphRequest), .busReq(busReq), .busRdata(busRdata),
  .busRvalid(busRvalid), .generalRequest(generalRequest),
  .fastRequest(fastRequest));

// file: testbench.sv
// Register level testbench of the interrupt controller
`timescale 1ns/1ps
module testbench;
  logic                       ref_clk;
  logic                       reset_n;
  logic [3:0]                 pinLevel;
  logic                       fastRequestIn;
  logic [2:0]                 userRequestIn;
  dlic_pkg::dlic_periph_type  periphRequest;
  dlic_pkg::dlic_bus_req_type busReq;
  logic [31:0]                busRdata;
  logic                       busRvalid;
  logic                       generalRequest;
  logic                       fastRequest;
  int                         error_cnt;
  int                         total_checks;
  int                         bitNo;

  dlic_pin_model pin_u (.levelReq(pinLevel), .fastRequestIn(fastRequestIn),
    .userRequestIn(userRequestIn));
  dlic_top dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .fastRequestIn(fastRequestIn), .userRequestIn(userRequestIn),
    .periphRequest(periphRequest), .busReq(busReq), .busRdata(busRdata),
    .busRvalid(busRvalid), .generalRequest(generalRequest),
    .fastRequest(fastRequest));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk) busReq.sel = 1'b0;
  endtask : idle

  // Leaves the request up so a following read lands back to back
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    busReq = '{1'b1, 1'b1, a, d};
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    @(negedge ref_clk);
    busReq = '{1'b1, 1'b0, a, 32'h0000_0000};
    @(negedge ref_clk);
    busReq.sel = 1'b0;
    for (int i = 0; i < 3 && busRvalid !== 1'b1; i++) @(negedge ref_clk);
    chk({31'h0000_0000, busRvalid}, 32'h0000_0001);
    chk(busRdata, exp);
  endtask : rd

  task automatic final_report;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Whole run is under two hundred cycles, far inside the 10000 cycle limit
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end

  initial begin
    error_cnt = 0;
    total_checks = 0;
    pinLevel = 4'h0;
    periphRequest = '0;
    busReq = '0;
    reset_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk) reset_n = 1'b1;
    // Address is nine bits: offsets 0x000, 0x004, 0x100 and 0x104
    for (int k = 0; k < 4; k++) begin
      rd({k[1], 5'h00, k[0], 2'h0}, 32'h0000_0000);
    end
    for (int k = 0; k < 11; k++) begin
      periphRequest = 11'h001 << k;
      bitNo = (k < 9) ? k + 2 : k + 5;
      idle(2);
      rd(9'h004, 32'h1 << bitNo);
      rd(9'h000, 32'h0000_0000);
    end
    periphRequest = '0;
    for (int k = 0; k < 4; k++) begin
      pinLevel = 4'h1 << k;
      idle(6);
      bitNo = (k < 3) ? k + 11 : 0;
      rd(9'h004, 32'h1 << bitNo);
    end
    rd(9'h104, 32'h0000_0001);
    wr(9'h108, 32'h0000_0001);
    idle(2);
    rd(9'h000, 32'h0000_0001);
    chk({31'h0000_0000, fastRequest}, 32'h0000_0001);
    wr(9'h10C, 32'h0000_0001);
    idle(1);
    pinLevel = 4'h0;
    wr(9'h008, 32'hFFFF_0019);
    rd(9'h008, 32'h0000_0018);
    wr(9'h00C, 32'h0000_0010);
    rd(9'h008, 32'h0000_0008);
    periphRequest.timer0 = 1'b1;
    idle(2);
    rd(9'h000, 32'h0000_0008);
    chk({31'h0000_0000, generalRequest}, 32'h0000_0001);
    wr(9'h110, 32'h0000_0008);
    idle(3);
    rd(9'h004, 32'h0000_0000);
    rd(9'h100, 32'h0000_0008);
    chk({30'h0, fastRequest, generalRequest}, 32'h2);
    wr(9'h110, 32'h0000_0000);
    idle(1);
    periphRequest = '0;
    idle(3);
    chk({31'h0000_0000, generalRequest}, 32'h0000_0000);
    wr(9'h008, 32'h0000_0002);
    wr(9'h010, 32'h0000_0002);
    idle(2);
    rd(9'h000, 32'h0000_0002);
    wr(9'h010, 32'h0000_0000);
    idle(2);
    rd(9'h004, 32'h0000_0000);
    wr(9'h004, 32'hFFFF_FFFF);
    rd(9'h004, 32'h0000_0000);
    rd(9'h020, 32'h0000_0000);
    rd(9'h00C, 32'h0000_0000);
    final_report();
  end
endmodule : testbench
